// >>> hdl/sap_fifo_ac97.sv
/*
  Four 15-word FIFOs with level counts and watermark flags, and the AC97
  frame scheduler with command and tag handling on the link clock.
  Assumes a shift engine on sys_clk that pushes and pops words, and a codec
  frame sync pin and receive tag strobe on the link clock.
*/
`include "sap_defs.svh"

module sap_fifo_ac97 (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              link_clk_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [31:0]       reg_rdata_out,
  input  wire logic [1:0]        rx_push_in,
  input  sap_pkg::sap_word_t     rx_word0_in,
  input  sap_pkg::sap_word_t     rx_word1_in,
  input  wire logic [1:0]        tx_pop_in,
  output sap_pkg::sap_word_t     tx_word0_out,
  output sap_pkg::sap_word_t     tx_word1_out,
  output logic      [1:0]        rx_full_flag_out,
  output logic      [1:0]        tx_empty_flag_out,
  input  wire logic              frame_sync_in,
  input  sap_pkg::sap_tag_t      rx_tag_in,
  input  wire logic              rx_tag_valid_in,
  output sap_pkg::sap_tag_t      tx_tag_out,
  output logic                   frame_active_out
);
  import sap_pkg::*;

  function automatic sap_cnt_t ptr_inc(input sap_cnt_t p);
    ptr_inc = (p == 4'hE) ? 4'h0 : 4'(p + 4'h1);
  endfunction

  function automatic sap_cnt_t cnt_step(input sap_cnt_t c, input logic up, input logic dn);
    cnt_step = 4'(c + {3'h0, up} - {3'h0, dn});
  endfunction

  // ---------------- system clock domain ----------------
  sap_word_t         rx_mem [0:1][0:14], tx_mem [0:1][0:14];
  sap_cnt_t          rx_cnt_r [0:1], tx_cnt_r [0:1];
  sap_cnt_t          rx_wp_r [0:1], rx_rp_r [0:1], tx_wp_r [0:1], tx_rp_r [0:1];
  sap_cnt_t          rx_wm_r [0:1], tx_wm_r [0:1];
  sap_cnt_t          rx_cnt_nxt [0:1], tx_cnt_nxt [0:1], rx_wm_nxt [0:1], tx_wm_nxt [0:1];
  logic [1:0]        rx_push_ok, rx_pop_ok, tx_push_ok, tx_pop_ok;
  sap_word_t         rx_pdata [0:1];
  logic [10:0]       acr_r;
  sap_tag_t          tag_hold_r, sw_tag_r;
  sap_word_t         tag_word_r;
  logic              tag_pend_r, tag_push, wr_fcsr, wr_acr, ac_en;
  // crossings
  logic              done_s1_r, done_s2_r, done_s3_r, rtag_s1_r, rtag_s2_r, rtag_s3_r;
  logic              ack_s1_r, ack_s2_r, cfg_req_r, cmd_done, rtag_evt;
  logic [25:0]       cfg_word_r, cfg_nxt;
  // link domain
  logic              fs_s1_r, fs_s2_r, fs_s3_r, lreq_s1_r, lreq_s2_r;
  logic              lack_r, lcmd_used_r, lcmd_sent_r, done_tgl_r, rtag_tgl_r, frm_start;
  logic [25:0]       lcfg_r;
  sap_tag_t          rtag_hold_r;
  logic [5:0]        idle_cnt_r;
  sap_frame_t        frm_r;

  assign wr_fcsr = reg_wr_in && (reg_addr_in == `SAP_OFF_FCSR);
  assign wr_acr  = reg_wr_in && (reg_addr_in == `SAP_OFF_ACR);
  assign ac_en   = acr_r[`SAP_ACR_EN];
  assign tag_push = tag_pend_r && !rx_push_in[0];
  assign cmd_done = done_s2_r ^ done_s3_r;
  assign rtag_evt = rtag_s2_r ^ rtag_s3_r;

  always_comb begin
    rx_pdata[0] = tag_push ? tag_word_r : rx_word0_in;
    rx_pdata[1] = rx_word1_in;
    for (int i = 0; i < 2; i++) begin
      rx_push_ok[i] = (rx_push_in[i] || (i == 0 && tag_push)) && (rx_cnt_r[i] != `SAP_FIFO_MAX);
      rx_pop_ok[i]  = reg_rd_in && (reg_addr_in == ((i == 0) ? `SAP_OFF_RX0 : `SAP_OFF_RX1))
                      && (rx_cnt_r[i] != 4'h0);
      tx_push_ok[i] = reg_wr_in && (reg_addr_in == ((i == 0) ? `SAP_OFF_TX0 : `SAP_OFF_TX1))
                      && (tx_cnt_r[i] != `SAP_FIFO_MAX);
      tx_pop_ok[i]  = tx_pop_in[i] && (tx_cnt_r[i] != 4'h0);
      rx_cnt_nxt[i] = cnt_step(rx_cnt_r[i], rx_push_ok[i], rx_pop_ok[i]);
      tx_cnt_nxt[i] = cnt_step(tx_cnt_r[i], tx_push_ok[i], tx_pop_ok[i]);
      rx_wm_nxt[i]  = rx_wm_r[i];
      tx_wm_nxt[i]  = tx_wm_r[i];
    end
    if (wr_fcsr) begin
      rx_wm_nxt[1] = reg_wdata_in[`SAP_RXWM1_LSB +: 4];
      tx_wm_nxt[1] = reg_wdata_in[`SAP_TXWM1_LSB +: 4];
      rx_wm_nxt[0] = reg_wdata_in[`SAP_RXWM0_LSB +: 4];
      tx_wm_nxt[0] = reg_wdata_in[`SAP_TXWM0_LSB +: 4];
    end
  end

  // fifo storage, no reset
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rx_push_ok[i]) begin
        rx_mem[i][rx_wp_r[i]] <= rx_pdata[i];
      end
      if (tx_push_ok[i]) begin
        tx_mem[i][tx_wp_r[i]] <= reg_wdata_in[19:0];
      end
    end
  end

  // pointers, counts, watermarks, flags
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 2; i++) begin
        rx_cnt_r[i] <= 4'h0;
        tx_cnt_r[i] <= 4'h0;
        rx_wp_r[i]  <= 4'h0;
        rx_rp_r[i]  <= 4'h0;
        tx_wp_r[i]  <= 4'h0;
        tx_rp_r[i]  <= 4'h0;
        rx_wm_r[i]  <= `SAP_RXWM_RST;
        tx_wm_r[i]  <= `SAP_TXWM_RST;
      end
      rx_full_flag_out  <= 2'h0;
      tx_empty_flag_out <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rx_push_ok[i]) rx_wp_r[i] <= ptr_inc(rx_wp_r[i]);
        if (rx_pop_ok[i])  rx_rp_r[i] <= ptr_inc(rx_rp_r[i]);
        if (tx_push_ok[i]) tx_wp_r[i] <= ptr_inc(tx_wp_r[i]);
        if (tx_pop_ok[i])  tx_rp_r[i] <= ptr_inc(tx_rp_r[i]);
        rx_cnt_r[i] <= rx_cnt_nxt[i];
        tx_cnt_r[i] <= tx_cnt_nxt[i];
        rx_wm_r[i]  <= rx_wm_nxt[i];
        tx_wm_r[i]  <= tx_wm_nxt[i];
        rx_full_flag_out[i]  <= (rx_cnt_nxt[i] >= rx_wm_nxt[i]);
        tx_empty_flag_out[i] <= (4'(`SAP_FIFO_MAX - tx_cnt_nxt[i]) >= tx_wm_nxt[i]);
      end
    end
  end

  // words handed to the transmit shifter
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_word0_out <= 20'h00000;
      tx_word1_out <= 20'h00000;
    end else begin
      if (tx_pop_ok[0]) tx_word0_out <= tx_mem[0][tx_rp_r[0]];
      if (tx_pop_ok[1]) tx_word1_out <= tx_mem[1][tx_rp_r[1]];
    end
  end

  // ac97 control; a software write wins over the self clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acr_r <= `SAP_ACR_RST;
    end else if (wr_acr) begin
      acr_r <= reg_wdata_in[`SAP_ACR_W-1:0];
    end else if (cmd_done) begin
      acr_r[`SAP_ACR_WR] <= 1'b0;
      acr_r[`SAP_ACR_RD] <= 1'b0;
    end
  end

  // received tag routing
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tag_hold_r <= 16'h0000;
      sw_tag_r   <= 16'h0000;
      tag_pend_r <= 1'b0;
      tag_word_r <= 20'h00000;
    end else begin
      if (reg_wr_in && reg_addr_in == `SAP_OFF_TAG) begin
        tag_hold_r <= reg_wdata_in[15:0];
        sw_tag_r   <= reg_wdata_in[15:0];
      end else if (rtag_evt && ac_en && !acr_r[`SAP_ACR_TIF]) begin
        tag_hold_r <= rtag_hold_r;
      end
      if (rtag_evt && ac_en && acr_r[`SAP_ACR_TIF]) begin
        tag_pend_r <= 1'b1;
        tag_word_r <= {4'h0, rtag_hold_r};
      end else if (tag_push) begin
        tag_pend_r <= 1'b0;
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `SAP_OFF_FCSR: reg_rdata_out <= {rx_cnt_r[1], tx_cnt_r[1], rx_wm_r[1], tx_wm_r[1],
                                         rx_cnt_r[0], tx_cnt_r[0], rx_wm_r[0], tx_wm_r[0]};
        `SAP_OFF_ACR:  reg_rdata_out <= {21'h000000, acr_r};
        `SAP_OFF_TAG:  reg_rdata_out <= {16'h0000, tag_hold_r};
        `SAP_OFF_RX0:  reg_rdata_out <= {12'h000, rx_mem[0][rx_rp_r[0]]};
        `SAP_OFF_RX1:  reg_rdata_out <= {12'h000, rx_mem[1][rx_rp_r[1]]};
        `SAP_OFF_STAT: reg_rdata_out <= {27'h0000000, cfg_req_r ^ ack_s2_r,
                                         tx_empty_flag_out, rx_full_flag_out};
        default:       reg_rdata_out <= 32'h00000000;
      endcase
    end
  end

  // link settings word; variable rate sends the live tag register
  always_comb begin
    cfg_nxt = {acr_r[`SAP_ACR_FV], ac_en, acr_r[`SAP_ACR_DIV_LSB +: 6], acr_r[`SAP_ACR_WR],
               acr_r[`SAP_ACR_RD], acr_r[`SAP_ACR_FV] ? tag_hold_r : sw_tag_r};
  end

  // handshake of settings, word held while unacknowledged
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_req_r  <= 1'b0;
      cfg_word_r <= 26'h0000000;
    end else if ((cfg_req_r == ack_s2_r) && (cfg_nxt != cfg_word_r)) begin
      cfg_word_r <= cfg_nxt;
      cfg_req_r  <= !cfg_req_r;
    end
  end

  // synchronisers into the system domain
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {done_s1_r, done_s2_r, done_s3_r} <= 3'h0;
      {rtag_s1_r, rtag_s2_r, rtag_s3_r} <= 3'h0;
      {ack_s1_r, ack_s2_r}              <= 2'h0;
    end else begin
      {done_s1_r, done_s2_r, done_s3_r} <= {done_tgl_r, done_s1_r, done_s2_r};
      {rtag_s1_r, rtag_s2_r, rtag_s3_r} <= {rtag_tgl_r, rtag_s1_r, rtag_s2_r};
      {ack_s1_r, ack_s2_r}              <= {lack_r, ack_s1_r};
    end
  end

  // ---------------- link clock domain ----------------
  assign frm_start = fs_s2_r && !fs_s3_r;

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {fs_s1_r, fs_s2_r, fs_s3_r} <= 3'h0;
      {lreq_s1_r, lreq_s2_r}      <= 2'h0;
    end else begin
      {fs_s1_r, fs_s2_r, fs_s3_r} <= {frame_sync_in, fs_s1_r, fs_s2_r};
      {lreq_s1_r, lreq_s2_r}      <= {cfg_req_r, lreq_s1_r};
    end
  end

  // capture of settings and retirement of commands
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lack_r      <= 1'b0;
      lcfg_r      <= 26'h0000000;
      lcmd_used_r <= 1'b0;
      lcmd_sent_r <= 1'b0;
      done_tgl_r  <= 1'b0;
    end else begin
      if (lreq_s2_r != lack_r) begin
        lcfg_r      <= cfg_word_r;
        lack_r      <= lreq_s2_r;
        lcmd_used_r <= 1'b0;
      end else if (frm_start && frm_r == FRM_ACTIVE && lcmd_sent_r) begin
        lcmd_used_r <= 1'b1;
      end
      if (frm_start) begin
        lcmd_sent_r <= 1'b0;
        if (lcmd_sent_r) done_tgl_r <= !done_tgl_r;
        if (lcfg_r[24] && idle_cnt_r == 6'h00 && !lcmd_used_r && (lcfg_r[17] || lcfg_r[16]))
          lcmd_sent_r <= 1'b1;
      end
    end
  end

  // frame scheduler and outgoing tag
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frm_r            <= FRM_OFF;
      idle_cnt_r       <= 6'h00;
      tx_tag_out       <= 16'h0000;
      frame_active_out <= 1'b0;
    end else if (frm_start) begin
      if (!lcfg_r[24]) begin
        frm_r            <= FRM_OFF;
        idle_cnt_r       <= 6'h00;
        frame_active_out <= 1'b0;
        tx_tag_out       <= 16'h0000;
      end else begin
        case (frm_r)
          FRM_OFF, FRM_ACTIVE, FRM_IDLE: begin
            if (idle_cnt_r == 6'h00) begin
              frm_r            <= FRM_ACTIVE;
              idle_cnt_r       <= lcfg_r[23:18];
              frame_active_out <= 1'b1;
              tx_tag_out       <= lcfg_r[15:0];
              tx_tag_out[`SAP_TAG_VALID] <= 1'b1;
              tx_tag_out[`SAP_TAG_CADDR] <= !lcmd_used_r && (lcfg_r[17] || lcfg_r[16]);
              tx_tag_out[`SAP_TAG_CDATA] <= !lcmd_used_r && lcfg_r[17];
            end else begin
              frm_r            <= FRM_IDLE;
              idle_cnt_r       <= 6'(idle_cnt_r - 6'h01);
              frame_active_out <= 1'b0;
              tx_tag_out       <= 16'h0000;
            end
          end
          default: frm_r <= FRM_OFF;
        endcase
      end
    end
  end

  // received tag handed across by toggle
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rtag_tgl_r  <= 1'b0;
      rtag_hold_r <= 16'h0000;
    end else if (rx_tag_valid_in && lcfg_r[24]) begin
      rtag_hold_r <= rx_tag_in;
      rtag_tgl_r  <= !rtag_tgl_r;
    end
  end

  // ---------------- checks ----------------
  sequence s_cmd_frame;
    frm_start && lcfg_r[24] && idle_cnt_r == 6'h00 && !lcmd_used_r;
  endsequence
  property p_rx_full;
    @(posedge sys_clk_in) disable iff (!rst_n_in) rx_full_flag_out[0] == (rx_cnt_r[0] >= rx_wm_r[0]);
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx full flag wrong");
  property p_tx_empty;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      tx_empty_flag_out[1] == (4'(4'hF - tx_cnt_r[1]) >= tx_wm_r[1]);
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty flag wrong");
  property p_tx_wm15;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (tx_wm_r[0] == 4'hF) |-> (tx_empty_flag_out[0] == (tx_cnt_r[0] == 4'h0));
  endproperty
  a_tx_wm15: assert property (p_tx_wm15) else $error("tx empty at watermark 15 wrong");
  property p_rx_count_up;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      rx_push_ok[1] && !rx_pop_ok[1] |=> rx_cnt_r[1] == 4'($past(rx_cnt_r[1]) + 4'h1)
        && rx_full_flag_out[1] == (rx_cnt_r[1] >= rx_wm_r[1]);
  endproperty
  a_rx_count_up: assert property (p_rx_count_up) else $error("rx count not updated");
  property p_fcsr_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in == `SAP_OFF_FCSR |=> reg_rdata_out[31:28] == $past(rx_cnt_r[1])
        && reg_rdata_out[27:24] == $past(tx_cnt_r[1]) && reg_rdata_out[15:12] == $past(rx_cnt_r[0]);
  endproperty
  a_fcsr_read: assert property (p_fcsr_read) else $error("fifo count readback wrong");
  property p_cmd_clear;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      cmd_done && !wr_acr |=> !acr_r[`SAP_ACR_WR] && !acr_r[`SAP_ACR_RD];
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command bit not cleared");
  property p_tag_reg;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      rtag_evt && ac_en && !acr_r[`SAP_ACR_TIF] && !(reg_wr_in && reg_addr_in == `SAP_OFF_TAG)
        |=> tag_hold_r == $past(rtag_hold_r) && !tag_pend_r;
  endproperty
  a_tag_reg: assert property (p_tag_reg) else $error("tag not stored in register");
  property p_wr_tags;
    @(posedge link_clk_in) disable iff (!rst_n_in)
      s_cmd_frame ##0 lcfg_r[17] |=> tx_tag_out[15:13] == 3'b111 && frame_active_out;
  endproperty
  a_wr_tags: assert property (p_wr_tags) else $error("write command tags wrong");
  property p_rd_tags;
    @(posedge link_clk_in) disable iff (!rst_n_in)
      s_cmd_frame ##0 (lcfg_r[16] && !lcfg_r[17]) |=> tx_tag_out[15:13] == 3'b110;
  endproperty
  a_rd_tags: assert property (p_rd_tags) else $error("read command tags wrong");
  property p_idle_frame;
    @(posedge link_clk_in) disable iff (!rst_n_in)
      frm_start && lcfg_r[24] && idle_cnt_r != 6'h00
        |=> !frame_active_out && idle_cnt_r == 6'($past(idle_cnt_r) - 6'h01);
  endproperty
  a_idle_frame: assert property (p_idle_frame) else $error("idle frame not honoured");
endmodule // sap_fifo_ac97

// >>> hdl/sap_defs.svh
/*
  Constants of the serial audio port FIFO level and AC97 command block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SAP_DEFS_SVH
`define SAP_DEFS_SVH
// register byte offsets
`define SAP_OFF_FCSR      8'h00
`define SAP_OFF_ACR       8'h04
`define SAP_OFF_TAG       8'h08
`define SAP_OFF_TX0       8'h0C
`define SAP_OFF_TX1       8'h10
`define SAP_OFF_RX0       8'h14
`define SAP_OFF_RX1       8'h18
`define SAP_OFF_STAT      8'h1C
// fifo control/status field positions (low bit)
`define SAP_RXCNT1_LSB    28
`define SAP_TXCNT1_LSB    24
`define SAP_RXWM1_LSB     20
`define SAP_TXWM1_LSB     16
`define SAP_RXCNT0_LSB    12
`define SAP_TXCNT0_LSB    8
`define SAP_RXWM0_LSB     4
`define SAP_TXWM0_LSB     0
// ac97 control field positions
`define SAP_ACR_DIV_LSB   5
`define SAP_ACR_WR        4
`define SAP_ACR_RD        3
`define SAP_ACR_TIF       2
`define SAP_ACR_FV        1
`define SAP_ACR_EN        0
`define SAP_ACR_W         11
// reset values and fifo full count
`define SAP_RXWM_RST      4'hF
`define SAP_TXWM_RST      4'h1
`define SAP_ACR_RST       11'h000
`define SAP_FIFO_MAX      4'hF
// outgoing tag slot bits
`define SAP_TAG_VALID     15
`define SAP_TAG_CADDR     14
`define SAP_TAG_CDATA     13
`endif

// >>> hdl/sap_pkg.sv
/*
  Types of the serial audio port FIFO level and AC97 command block.
  Assumes nothing beyond the constants header.
*/
package sap_pkg;
  typedef logic [3:0]  sap_cnt_t;
  typedef logic [19:0] sap_word_t;
  typedef logic [15:0] sap_tag_t;
  typedef enum logic [1:0] {
    FRM_OFF    = 2'b00,
    FRM_ACTIVE = 2'b01,
    FRM_IDLE   = 2'b10
  } sap_frame_t;
endpackage

// >>> verif/sap_codec_model.sv
/*
  Codec side of the link: frame sync pulses and received slot 0 tags.
  Assumes a free running link clock made by the bench.
*/
module sap_codec_model (
  input  wire logic        link_clk_in,
  output logic             frame_sync_out,
  output logic [15:0]      tag_out,
  output logic             tag_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    frame_sync_out = 1'b0;
    tag_out        = 16'h0000;
    tag_valid_out  = 1'b0;
  end
  // sync high two cycles, tag one cycle, then a long gap
  task automatic send_frame(input logic [15:0] tag);
    @(posedge link_clk_in);
    frame_sync_out <= 1'b1;
    @(posedge link_clk_in);
    tag_out       <= tag;
    tag_valid_out <= 1'b1;
    @(posedge link_clk_in);
    frame_sync_out <= 1'b0;
    tag_valid_out  <= 1'b0;
    tag_out        <= ~tag;
    repeat (24) @(posedge link_clk_in);
  endtask
endmodule // sap_codec_model

// >>> verif/testbench.sv
/*
  Register level tests of fifo levels, watermark flags and ac97 commands.
  Assumes the codec model on the link side and a 15 ns link clock.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clk = 1'b0;
  logic               lclk = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         addr = 8'h00;
  logic [31:0]        wdata = 32'h0;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [31:0]        rdata;
  logic [1:0]         push = 2'b00;
  logic [19:0]        w0 = 20'h0;
  logic [19:0]        w1 = 20'h0;
  logic [1:0]         pop = 2'b00;
  logic [19:0]        t0, t1;
  logic [1:0]         rxf, txe;
  logic               fs, tv, fact;
  logic [15:0]        rtag, ttag;
  logic [31:0]        d;
  logic [3:0]         n;
  int                 bad_count = 0;
  int                 check_count = 0;
  always #20 clk = ~clk;
  initial begin
    #3;
    forever #7.5 lclk = ~lclk;
  end
  sap_fifo_ac97 sap_fifo_ac97_i (.sys_clk_in(clk), .rst_n_in(rst_n), .link_clk_in(lclk),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .rx_push_in(push), .rx_word0_in(w0), .rx_word1_in(w1),
    .tx_pop_in(pop), .tx_word0_out(t0), .tx_word1_out(t1), .rx_full_flag_out(rxf),
    .tx_empty_flag_out(txe), .frame_sync_in(fs), .rx_tag_in(rtag), .rx_tag_valid_in(tv),
    .tx_tag_out(ttag), .frame_active_out(fact));
  sap_codec_model sap_codec_model_i (.link_clk_in(lclk), .frame_sync_out(fs), .tag_out(rtag),
    .tag_valid_out(tv));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and unmapped place
    reg_rd(8'h00, d);
    chk(d, 32'h00F100F1, "fcsr reset");
    reg_rd(8'h04, d);
    chk(d, 32'h0, "acr reset");
    reg_rd(8'h40, d);
    chk(d, 32'h0, "unmapped read");
    reg_rd(8'h1C, d);
    chk(d, 32'h0000000C, "status reset");
    chk({28'h0, rxf, txe}, 32'h3, "reset flags");
    $display("test reset done");
    // tx fill past full: tx0 watermark 15, tx1 default
    reg_wr(8'h00, 32'h00F1004F);
    for (int k = 1; k <= 16; k++) begin
      n = (k > 15) ? 4'hF : 4'(k);
      reg_wr(8'h0C, 32'h10000 + k);
      reg_wr(8'h10, 32'h20000 + k);
      chk({30'h0, txe}, {30'h0, n < 4'hF, 1'b0}, "tx flags");
      reg_rd(8'h00, d);
      chk(d & 32'h0F000F00, {4'h0, n, 12'h000, n, 8'h00}, "tx counts");
    end
    for (int k = 1; k <= 15; k++) begin
      @(posedge clk);
      pop <= 2'b11;
      @(posedge clk);
      pop <= 2'b00;
      @(posedge clk);
      chk({12'h000, t1}, 32'h20000 + k, "tx1 word");
      chk({12'h000, t0}, 32'h10000 + k, "tx0 word");
    end
    chk({30'h0, txe}, 32'h3, "tx drained flags");
    $display("test tx done");
    // rx fill past full: rx0 watermark 4, rx1 default
    for (int k = 1; k <= 16; k++) begin
      n = (k > 15) ? 4'hF : 4'(k);
      @(posedge clk);
      push <= 2'b11;
      w0   <= 20'h30000 + 20'(k);
      w1   <= 20'h40000 + 20'(k);
      @(posedge clk);
      push <= 2'b00;
      #1;
      chk({30'h0, rxf}, {30'h0, n == 4'hF, n >= 4'h4}, "rx flags");
      reg_rd(8'h00, d);
      chk(d & 32'hF000F000, {n, 12'h000, n, 12'h000}, "rx counts");
    end
    for (int k = 1; k <= 15; k++) begin
      reg_rd(8'h14, d);
      chk(d, 32'h30000 + k, "rx0 word");
      reg_rd(8'h18, d);
      chk(d, 32'h40000 + k, "rx1 word");
    end
    chk({30'h0, rxf}, 32'h0, "rx drained flags");
    // pushes to neither, each single channel, then both; pops on empty tx fifos are refused
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      push <= 2'(k);
      pop  <= 2'(3 - k);
      w0   <= 20'h50000 + 20'(k);
      w1   <= 20'h60000 + 20'(k);
    end
    @(posedge clk);
    push <= 2'b00;
    pop  <= 2'b00;
    reg_rd(8'h00, d);
    chk(d & 32'hFF00FF00, 32'h20002000, "single channel counts");
    chk({12'h000, t1}, 32'h0002000F, "tx1 word held");
    chk({12'h000, t0}, 32'h0001000F, "tx0 word held");
    for (int k = 1; k <= 2; k++) begin
      reg_rd(8'h14, d);
      chk(d, 32'h50000 + 2 * k - 1, "rx0 single word");
      reg_rd(8'h18, d);
      chk(d, 32'h60001 + k, "rx1 single word");
    end
    $display("test rx done");
    // write command, one idle frame, self clear
    reg_wr(8'h08, 32'h00000ACE);
    reg_wr(8'h04, 32'h00000031);
    repeat (12) @(posedge clk);
    sap_codec_model_i.send_frame(16'h1234);
    chk({31'h0, fact}, 32'h1, "active frame");
    chk({16'h0, ttag}, {16'h0, 3'b111, 13'h0ACE}, "write tag");
    sap_codec_model_i.send_frame(16'h1234);
    chk({31'h0, fact}, 32'h0, "idle frame");
    repeat (10) @(posedge clk);
    reg_rd(8'h04, d);
    chk(d, 32'h00000021, "write cleared");
    reg_rd(8'h08, d);
    chk(d, 32'h00001234, "tag held");
    // read command in variable mode
    reg_wr(8'h04, 32'h0000002B);
    repeat (12) @(posedge clk);
    sap_codec_model_i.send_frame(16'h1234);
    chk({31'h0, fact}, 32'h1, "active frame 2");
    chk({16'h0, ttag}, {16'h0, 3'b110, 13'h1234}, "read tag");
    sap_codec_model_i.send_frame(16'h1234);
    repeat (10) @(posedge clk);
    reg_rd(8'h04, d);
    chk(d, 32'h0000002B & 32'hFFFFFFF7, "read cleared");
    $display("test command done");
    // tag into rx fifo 0
    reg_wr(8'h04, 32'h00000005);
    repeat (12) @(posedge clk);
    sap_codec_model_i.send_frame(16'h9ABC);
    repeat (10) @(posedge clk);
    reg_rd(8'h00, d);
    chk(d & 32'h0000F000, 32'h00001000, "tag pushed");
    reg_rd(8'h14, d);
    chk(d, 32'h00009ABC, "tag word");
    // disabled: no active frames
    reg_wr(8'h04, 32'h00000000);
    repeat (12) @(posedge clk);
    sap_codec_model_i.send_frame(16'h4321);
    chk({15'h0, fact, ttag}, 32'h0, "disabled frame");
    $display("test tag done");
    stop_test;
  end
endmodule // testbench
